// >>> rtl/rcc_cfg.svh
`ifndef RCC_CFG_SVH
`define RCC_CFG_SVH

// register offsets
`define RCC_ADDR_STATUS     8'h03
`define RCC_ADDR_SCRATCH    8'h08
`define RCC_ADDR_CONFIG     8'h10
`define RCC_ADDR_IRQ_STAT   8'h11
`define RCC_ADDR_IRQ_MASK   8'h12

// status field positions and power-on value
`define RCC_STATUS_POR      8'h18
`define RCC_ST_TO_BIT       4
`define RCC_ST_PD_BIT       3

// configuration word fields
`define RCC_CFG_WATCHDOG_ENABLE_BIT    2
`define RCC_CFG_CP_MSB      11
`define RCC_CFG_CP_LSB      3
`define RCC_CFG_RESET       12'hfff

// interrupt status bits
`define RCC_EV_POR          0
`define RCC_EV_MASTER_CLEAR_N_RUN     1
`define RCC_EV_MASTER_CLEAR_N_WAKE    2
`define RCC_EV_WDT_RUN      3
`define RCC_EV_WDT_WAKE     4

// timing
`define RCC_CLK_MHZ         125
`define RCC_WDT_NOM_US      18000
`define RCC_WDT_CYCLES      (`RCC_WDT_NOM_US * `RCC_CLK_MHZ)
`define RCC_HOLD_CYCLES     4'h8

`endif

// >>> rtl/rcc_pkg.sv
package rcc_pkg;

  typedef enum logic [1:0] {
    RCC_LOW_POWER_CRYSTAL  = 2'h0,
    RCC_STANDARD_CRYSTAL   = 2'h1,
    RCC_HIGH_SPEED_CRYSTAL = 2'h2,
    RCC_RESISTOR_CAP_OSC   = 2'h3
  } rcc_osc_t;

  // gray along hold -> run -> sleep
  typedef enum logic [1:0] {
    RCC_HOLD  = 2'h3,
    RCC_RUN   = 2'h1,
    RCC_SLEEP = 2'h0
  } rcc_fsm_t;

  typedef struct packed {
    logic page_bit_2;
    logic page_bit_1;
    logic page_bit_0;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic zero_flag;
    logic digit_carry_flag;
    logic carry_flag;
  } rcc_status_t;

  typedef struct packed {
    logic [8:0] code_protect;
    logic       watchdog_enable;
    rcc_osc_t   oscillator_select;
  } rcc_config_t;

  typedef struct packed {
    logic [21:0] cnt;
    logic        expire;
  } rcc_wdt_state_t;

  typedef struct packed {
    rcc_fsm_t    fsm;
    logic [3:0]  hold_cnt;
    logic        dev_reset;
    logic        master_clear_n_prev;
    rcc_status_t status;
    rcc_config_t cfg;
    logic [7:0]  scratch;
    logic [4:0]  irq_stat;
    logic [4:0]  irq_mask;
    logic        irq;
    logic        asleep;
    logic        prot_on;
    logic [7:0]  rdata;
  } rcc_state_t;

endpackage : rcc_pkg

// >>> rtl/rcc_top.sv
`timescale 1ns/1ps
`include "rcc_cfg.svh"

module rcc_top #(
  parameter int unsigned WDT_CYCLES = `RCC_WDT_CYCLES
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          master_clear_n,
  input  wire logic          sleep_enter,
  input  wire logic          wdt_kick,
  input  wire logic [11:0]   config_word,
  input  wire logic [7:0]    addr,
  input  wire logic [7:0]    wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic [7:0]         rdata,
  output logic               irq,
  output logic               dev_reset,
  output logic               sleeping,
  output logic               timeout_flag_n,
  output logic               powerdown_flag_n,
  output logic               watchdog_enable,
  output rcc_pkg::rcc_osc_t  oscillator_select,
  output logic               code_protect_on
);
  import rcc_pkg::*;

  rcc_state_t q, d;
  logic       wdt_expire;
  logic       wdt_restart;
  logic       in_sleep;
  logic       master_clear_n_ev;
  logic       wdt_ev;
  logic       cp_on;

  assign in_sleep    = (q.fsm == RCC_SLEEP);
  assign master_clear_n_ev     = q.master_clear_n_prev && !master_clear_n;
  assign wdt_ev      = wdt_expire && q.cfg.watchdog_enable;
  assign wdt_restart = q.dev_reset || wdt_kick || (sleep_enter && q.fsm == RCC_RUN);
  assign cp_on       = ~&q.cfg.code_protect;

  rcc_wdt #(
    .CYCLES (WDT_CYCLES)
  ) u_wdt (
    .mclk    (mclk),
    .rst     (rst),
    .enable  (q.cfg.watchdog_enable),
    .restart (wdt_restart),
    .expire  (wdt_expire)
  );

  always_comb begin
    logic [4:0] ev;
    logic       rd_irq;
    ev     = '0;
    rd_irq = rd && (addr == `RCC_ADDR_IRQ_STAT);
    d      = q;
    d.rdata     = '0;
    d.master_clear_n_prev = master_clear_n;

    // cause classification and status update
    if (master_clear_n_ev) begin
      d.status.page_bit_2 = 1'b0;
      d.status.page_bit_1 = 1'b0;
      d.status.page_bit_0 = 1'b0;
      if (in_sleep) begin
        d.status.timeout_flag_n   = 1'b1;
        d.status.powerdown_flag_n = 1'b0;
        ev[`RCC_EV_MASTER_CLEAR_N_WAKE]     = 1'b1;
      end else begin
        ev[`RCC_EV_MASTER_CLEAR_N_RUN] = 1'b1;
      end
    end else if (wdt_ev) begin
      d.status.page_bit_2     = 1'b0;
      d.status.page_bit_1     = 1'b0;
      d.status.page_bit_0     = 1'b0;
      d.status.timeout_flag_n = 1'b0;
      if (in_sleep) begin
        d.status.powerdown_flag_n = 1'b0;
        ev[`RCC_EV_WDT_WAKE]      = 1'b1;
      end else begin
        d.status.powerdown_flag_n = 1'b1;
        ev[`RCC_EV_WDT_RUN]       = 1'b1;
      end
    end

    // sequencing: any event forces a full device reset, also from sleep
    if (master_clear_n_ev || wdt_ev) begin
      d.fsm       = RCC_HOLD;
      d.hold_cnt  = '0;
      d.dev_reset = 1'b1;
      d.irq_mask  = '0;
    end else begin
      case (q.fsm)
        RCC_HOLD: begin
          if (!master_clear_n) begin
            d.hold_cnt = '0;
          end else if (q.hold_cnt == `RCC_HOLD_CYCLES - 4'h1) begin
            d.fsm       = RCC_RUN;
            d.dev_reset = 1'b0;
          end else begin
            d.hold_cnt = q.hold_cnt + 4'h1;
          end
        end
        RCC_RUN: begin
          if (sleep_enter) begin
            d.fsm = RCC_SLEEP;
          end
        end
        RCC_SLEEP: begin
          d.fsm = RCC_SLEEP;
        end
        default: begin
          d.fsm = RCC_HOLD;
        end
      endcase
    end

    // register writes, ignored while the core is held in reset
    if (wr && !q.dev_reset && !master_clear_n_ev && !wdt_ev) begin
      case (addr)
        `RCC_ADDR_STATUS: begin
          d.status.page_bit_2       = wdata[7];
          d.status.page_bit_1       = wdata[6];
          d.status.page_bit_0       = wdata[5];
          d.status.zero_flag        = wdata[2];
          d.status.digit_carry_flag = wdata[1];
          d.status.carry_flag       = wdata[0];
        end
        `RCC_ADDR_SCRATCH:  d.scratch  = wdata;
        `RCC_ADDR_IRQ_MASK: d.irq_mask = wdata[4:0];
        default: begin
        end
      endcase
    end
    if (wr && (addr == `RCC_ADDR_SCRATCH) && (master_clear_n_ev || wdt_ev || q.dev_reset)) begin
      d.scratch = q.scratch;
    end

    // register reads
    if (rd) begin
      case (addr)
        `RCC_ADDR_STATUS:   d.rdata = q.status;
        `RCC_ADDR_SCRATCH:  d.rdata = q.scratch;
        `RCC_ADDR_CONFIG:   d.rdata = {3'h0, q.cfg.watchdog_enable, cp_on, 1'b0, q.cfg.oscillator_select};
        `RCC_ADDR_IRQ_STAT: d.rdata = {3'h0, q.irq_stat};
        `RCC_ADDR_IRQ_MASK: d.rdata = {3'h0, q.irq_mask};
        default:            d.rdata = '0;
      endcase
    end

    // sticky events, set wins over the read clear
    d.irq_stat = (rd_irq ? 5'h00 : q.irq_stat) | ev;

    // power-on: everything but scratch to defined values
    if (rst) begin
      d.fsm         = RCC_HOLD;
      d.hold_cnt    = '0;
      d.dev_reset   = 1'b1;
      d.master_clear_n_prev   = 1'b1;
      d.status      = `RCC_STATUS_POR;
      d.cfg         = rcc_config_t'(config_word);
      d.scratch     = q.scratch;
      d.irq_stat    = 5'h01 << `RCC_EV_POR;
      d.irq_mask    = '0;
      d.rdata       = '0;
    end

    d.irq = |(d.irq_stat & d.irq_mask);
    // registered copies so every output leaves a flop
    d.asleep  = (d.fsm == RCC_SLEEP);
    d.prot_on = ~&d.cfg.code_protect;
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end

  assign rdata             = q.rdata;
  assign irq               = q.irq;
  assign dev_reset         = q.dev_reset;
  assign sleeping          = q.asleep;
  assign timeout_flag_n    = q.status.timeout_flag_n;
  assign powerdown_flag_n  = q.status.powerdown_flag_n;
  assign watchdog_enable   = q.cfg.watchdog_enable;
  assign oscillator_select = q.cfg.oscillator_select;
  assign code_protect_on   = q.prot_on;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence run_master_clear_n_s;
    master_clear_n_ev && !in_sleep;
  endsequence

  sequence wake_master_clear_n_s;
    master_clear_n_ev && in_sleep;
  endsequence

  sequence run_wdt_s;
    !master_clear_n_ev && wdt_ev && !in_sleep;
  endsequence

  sequence wake_wdt_s;
    !master_clear_n_ev && wdt_ev && in_sleep;
  endsequence

  sequence hold_s;
    dev_reset [*8];
  endsequence

  por_flags_a: assert property ($fell(rst) |-> q.status[7:3] == 5'h03)
    else $error("power-on status not 0001 1");
  master_clear_n_run_a: assert property (run_master_clear_n_s |=> $stable({timeout_flag_n, powerdown_flag_n}))
    else $error("run clear changed cause flags");
  master_clear_n_wake_a: assert property (wake_master_clear_n_s |=> timeout_flag_n && !powerdown_flag_n)
    else $error("clear wake flags wrong");
  wdt_run_a: assert property (run_wdt_s |=> !timeout_flag_n && powerdown_flag_n)
    else $error("run watchdog flags wrong");
  wdt_wake_a: assert property (wake_wdt_s |=> !timeout_flag_n && !powerdown_flag_n)
    else $error("watchdog wake flags wrong");
  page_clear_a: assert property (master_clear_n_ev || wdt_ev |=> q.status[7:5] == 3'h0 && $stable(q.status[2:0]))
    else $error("pages not cleared or arith flags lost");
  wake_reset_a: assert property ((wake_master_clear_n_s or wake_wdt_s) |=> hold_s)
    else $error("wake did not hold the core in reset");
  wake_release_a: assert property ((wake_master_clear_n_s or wake_wdt_s) ##1 master_clear_n [*8] |=> !dev_reset)
    else $error("wake reset not released after hold");
  wdt_gate_a: assert property (!watchdog_enable |-> !wdt_expire ##1 !$fell(timeout_flag_n))
    else $error("watchdog event while disabled");
  sleep_mark_a: assert property (q.fsm == RCC_RUN && sleep_enter && !master_clear_n_ev && !wdt_ev |=> sleeping)
    else $error("sleep indicator not set");
  irq_level_a: assert property (irq == |(q.irq_stat & q.irq_mask))
    else $error("interrupt level mismatch");
  irq_sticky_a: assert property (!(rd && addr == `RCC_ADDR_IRQ_STAT) |=>
                                 (q.irq_stat & $past(q.irq_stat)) == $past(q.irq_stat))
    else $error("sticky event bit lost without a read");

endmodule : rcc_top

// >>> rtl/rcc_wdt.sv
`timescale 1ns/1ps
`include "rcc_cfg.svh"

module rcc_wdt #(
  parameter int unsigned CYCLES = `RCC_WDT_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic restart,
  output logic      expire
);
  import rcc_pkg::*;

  rcc_wdt_state_t q, d;

  always_comb begin
    d        = q;
    d.expire = 1'b0;
    if (rst || restart || !enable) begin
      d.cnt = '0;
    end else if (q.cnt == 22'(CYCLES - 1)) begin
      d.cnt    = '0;
      d.expire = 1'b1;
    end else begin
      d.cnt = q.cnt + 22'h1;
    end
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end

  assign expire = q.expire;

endmodule : rcc_wdt

// >>> verification/rcc_pin_model.sv
`timescale 1ns/1ps
// external clear pin, pulled up when nobody presses it
module rcc_pin_model (
  input  wire logic mclk,
  output logic      master_clear_n
);
  initial master_clear_n = 1'b1;

  task automatic press(input int n);
    @(posedge mclk);
    master_clear_n <= 1'b0;
    repeat (n) @(posedge mclk);
    master_clear_n <= 1'b1;
    #1;
  endtask : press
endmodule : rcc_pin_model

// >>> verification/rcc_top_tb.sv
`timescale 1ns/1ps
`include "rcc_cfg.svh"
module rcc_top_tb;
  import rcc_pkg::*;
  logic             mclk = 1'b0;
  logic             rst = 1'b1;
  logic             sleep_enter = 1'b0;
  logic             wdt_kick = 1'b0;
  logic             wr = 1'b0;
  logic             rd = 1'b0;
  logic [11:0]      config_word = 12'h003;
  logic [7:0]       addr = 8'h00;
  logic [7:0]       wdata = 8'h00;
  logic [7:0]       rdata;
  logic             irq, dev_reset, sleeping, master_clear_n;
  logic             timeout_flag_n, powerdown_flag_n, watchdog_enable, code_protect_on;
  rcc_osc_t         oscillator_select;
  int               err_total = 0;
  int               compares = 0;

  always #4 mclk = ~mclk;

  rcc_pin_model u_rcc_pin_model (.mclk(mclk), .master_clear_n(master_clear_n));

  rcc_top #(.WDT_CYCLES(50)) u_rcc_top (
    .mclk(mclk), .rst(rst), .master_clear_n(master_clear_n), .sleep_enter(sleep_enter),
    .wdt_kick(wdt_kick), .config_word(config_word), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .dev_reset(dev_reset), .sleeping(sleeping),
    .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n),
    .watchdog_enable(watchdog_enable), .oscillator_select(oscillator_select),
    .code_protect_on(code_protect_on));

  task automatic report_and_stop();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : bus_wr

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    rd <= 1'b1; addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(n, {4'h0, e}, {4'h0, rdata});
  endtask : rd_chk

  // bounded wait for the core reset level
  task automatic wait_dr(input logic lvl);
    int i;
    for (i = 0; i < 200 && dev_reset !== lvl; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("dev_reset", {11'h0, lvl}, {11'h0, dev_reset});
  endtask : wait_dr

  task automatic pon(input logic [11:0] cfg);
    @(posedge mclk);
    rst <= 1'b1; config_word <= cfg;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("dev_reset_hold", 12'h1, {11'h0, dev_reset});
    wait_dr(1'b0);
  endtask : pon

  task automatic nap();
    @(posedge mclk);
    sleep_enter <= 1'b1;
    @(posedge mclk);
    sleep_enter <= 1'b0;
    #1;
    chk("sleeping", 12'h1, {11'h0, sleeping});
  endtask : nap

  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  initial begin
    pon(12'h003);
    rd_chk("status_por", `RCC_ADDR_STATUS, 8'h18);
    chk("flags", 12'h3, {10'h0, timeout_flag_n, powerdown_flag_n});
    rd_chk("config", `RCC_ADDR_CONFIG, 8'h0b);
    chk("cfg_out", 12'h7, {9'h0, watchdog_enable, code_protect_on, oscillator_select});
    rd_chk("unmapped", 8'h20, 8'h00);
    chk("irq_masked", 12'h0, {11'h0, irq});
    bus_wr(`RCC_ADDR_IRQ_MASK, 8'h01);
    rd_chk("mask", `RCC_ADDR_IRQ_MASK, 8'h01);
    chk("irq_on", 12'h1, {11'h0, irq});
    rd_chk("irq_stat_por", `RCC_ADDR_IRQ_STAT, 8'h01);
    @(posedge mclk); #1;
    chk("irq_off", 12'h0, {11'h0, irq});
    bus_wr(`RCC_ADDR_STATUS, 8'hff);
    bus_wr(`RCC_ADDR_SCRATCH, 8'h5a);
    rd_chk("status_wr", `RCC_ADDR_STATUS, 8'hff);
    u_rcc_pin_model.press(3);
    wait_dr(1'b0);
    rd_chk("status_clr_run", `RCC_ADDR_STATUS, 8'h1f);
    rd_chk("scratch_kept", `RCC_ADDR_SCRATCH, 8'h5a);
    rd_chk("irq_clr_run", `RCC_ADDR_IRQ_STAT, 8'h02);
    rd_chk("mask_reset", `RCC_ADDR_IRQ_MASK, 8'h00);
    nap();
    u_rcc_pin_model.press(3);
    chk("wake_reset", 12'h2, {10'h0, dev_reset, sleeping});
    wait_dr(1'b0);
    rd_chk("status_clr_wake", `RCC_ADDR_STATUS, 8'h17);
    rd_chk("irq_clr_wake", `RCC_ADDR_IRQ_STAT, 8'h04);
    repeat (200) @(posedge mclk);
    #1;
    chk("wdt_off", 12'h0, {11'h0, dev_reset});
    for (int k = 0; k < 4; k++) begin
      pon({9'h1ff, 1'b0, k[1:0]});
      chk("osc", {10'h0, k[1:0]}, {10'h0, oscillator_select});
      rd_chk("config_osc", `RCC_ADDR_CONFIG, {6'h0, k[1:0]});
    end
    pon(12'hffd);
    rd_chk("config_wdt", `RCC_ADDR_CONFIG, 8'h11);
    chk("cfg_out2", 12'h9, {9'h0, watchdog_enable, code_protect_on, oscillator_select});
    for (int k = 0; k < 10; k++) begin
      repeat (20) @(posedge mclk);
      wdt_kick <= 1'b1;
      @(posedge mclk);
      wdt_kick <= 1'b0;
      #1;
      chk("kicked", 12'h0, {11'h0, dev_reset});
    end
    wait_dr(1'b1);
    wait_dr(1'b0);
    rd_chk("status_wdt_run", `RCC_ADDR_STATUS, 8'h08);
    rd_chk("irq_wdt_run", `RCC_ADDR_IRQ_STAT, 8'h09);
    nap();
    wait_dr(1'b1);
    chk("wdt_wake", 12'h0, {11'h0, sleeping});
    wait_dr(1'b0);
    rd_chk("status_wdt_wake", `RCC_ADDR_STATUS, 8'h00);
    rd_chk("irq_wdt_wake", `RCC_ADDR_IRQ_STAT, 8'h10);
    report_and_stop();
  end
endmodule : rcc_top_tb
